// *** inc/axlcs_pkg.sv ***
// register map, field layout, reset values and carriers for the control slave
// assumes a classic wishbone master with byte addresses and 32-bit data
package axlcs_pkg;

  localparam int unsigned AW = 12;
  localparam int unsigned DW = 32;
  localparam int unsigned SW = 4;

  // port data widths (one byte each)
  localparam int unsigned ARG_W = 8;

  // block-level control window, kept free of port registers
  localparam logic [AW-1:0] ADR_CTRL   = 12'h000;
  localparam logic [AW-1:0] ADR_GIE    = 12'h004;
  localparam logic [AW-1:0] ADR_IER    = 12'h008;
  localparam logic [AW-1:0] ADR_ISR    = 12'h00C;
  localparam logic [AW-1:0] ADR_RSV_HI = 12'h00C;

  // automatically placed port registers
  localparam logic [AW-1:0] ADR_A      = 12'h010;
  localparam logic [AW-1:0] ADR_B      = 12'h018;
  localparam logic [AW-1:0] ADR_B_VLD  = 12'h01C;
  localparam logic [AW-1:0] ADR_B_ACK  = 12'h020;

  // explicitly placed port register
  localparam logic [AW-1:0] ADR_C      = 12'h400;

  // control register fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_DONE  = 1;
  localparam int unsigned CTRL_IDLE  = 2;
  localparam int unsigned CTRL_READY = 3;
  localparam int unsigned CTRL_AUTO  = 7;

  // interrupt fields
  localparam int unsigned GIE_BIT   = 0;
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_READY = 1;
  localparam int unsigned IRQ_N     = 2;

  // handshake register fields
  localparam int unsigned HSK_BIT = 0;

  // reset values
  localparam logic [DW-1:0]    DATA_RST = 32'h0000_0000;
  localparam logic [IRQ_N-1:0] IRQ_RST  = 2'h0;

  typedef struct packed {
    logic [AW-1:0] adr;
    logic [DW-1:0] dat;
    logic [SW-1:0] sel;
    logic          we;
    logic          cyc;
    logic          stb;
  } axlcs_wb_req_t;

  typedef struct packed {
    logic [DW-1:0] dat;
    logic          ack;
  } axlcs_wb_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_A,
    ST_WAIT_B,
    ST_CALC,
    ST_DONE
  } axlcs_state_t;

endpackage

// *** design/axlcs_arg_reg.sv ***
// one software-written argument register, optionally loaded by the core
// assumes write strobes already qualified by the bus decode
`timescale 1ns/10ps
`default_nettype none
module axlcs_arg_reg #(
  parameter int unsigned W        = 8,
  parameter bit          RESET_EN = 1'b1
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  // software side
  input  wire logic         wr_en_i,
  input  wire logic [W-1:0] wr_dat_i,
  // core side, wins over software
  input  wire logic         ld_en_i,
  input  wire logic [W-1:0] ld_dat_i,
  // value
  output logic      [W-1:0] q_o
);
  logic [W-1:0] q_d;

  always_comb begin
    q_d = q_o;
    if (ld_en_i) begin
      q_d = ld_dat_i;
    end else if (wr_en_i) begin
      q_d = wr_dat_i;
    end
  end

  generate
    if (RESET_EN) begin : g_rst
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          q_o <= axlcs_pkg::DATA_RST[W-1:0];
        end else begin
          q_o <= q_d;
        end
      end
    end else begin : g_norst
      always_ff @(posedge clock_i) begin
        q_o <= q_d;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** design/axlcs_hsk_port.sv ***
// valid and acknowledge registers of one handshaked argument
// assumes consume_i only pulses while valid_o is high
`timescale 1ns/10ps
`default_nettype none
module axlcs_hsk_port (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // software writes the valid register
  input  wire logic vld_wr_i,
  input  wire logic vld_dat_i,
  // core takes the data
  input  wire logic consume_i,
  // registers
  output logic      valid_o,
  output logic      ack_o
);
  // core clears valid
  // a software write in the same cycle wins so a fresh value is not dropped
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
    end else if (vld_wr_i) begin
      valid_o <= vld_dat_i;
    end else if (consume_i) begin
      valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_o <= 1'b0;
    end else if (consume_i) begin
      ack_o <= 1'b1;
    end else if (vld_wr_i && vld_dat_i) begin
      ack_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** design/axlcs_top.sv ***
// control slave with its small core: c = c + a + b, b handshaked
// assumes one classic wishbone master on the same clock as the core
`timescale 1ns/10ps
`default_nettype none
module axlcs_top #(
  parameter bit REG_RESET_EN = 1'b1
) (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     sys_rst_i,
  // register bus
  input  wire axlcs_pkg::axlcs_wb_req_t wb_req_i,
  output var  axlcs_pkg::axlcs_wb_rsp_t wb_rsp_o,
  // block status
  output logic                          irq_o,
  output logic                          idle_o,
  output logic                          b_ack_o
);
  localparam int unsigned W = axlcs_pkg::ARG_W;

  logic                              req;
  logic                              ack_q;
  logic [axlcs_pkg::AW-1:0]          adr_w;
  logic                              wr_cmt;
  logic                              rd_take;
  logic                              wr_b0;
  logic [axlcs_pkg::DW-1:0]          rdata_d;
  logic [axlcs_pkg::DW-1:0]          rdata_q;

  logic                              start_q;
  logic                              done_q;
  logic                              auto_q;
  logic                              gie_q;
  logic [axlcs_pkg::IRQ_N-1:0]       ier_q;
  logic [axlcs_pkg::IRQ_N-1:0]       isr_q;
  logic [axlcs_pkg::IRQ_N-1:0]       isr_set;
  logic [axlcs_pkg::IRQ_N-1:0]       isr_clr;

  axlcs_pkg::axlcs_state_t           state_q;
  axlcs_pkg::axlcs_state_t           state_d;
  logic                              ready_evt;
  logic                              done_evt;
  logic                              b_take;
  logic [W-1:0]                      op_a_q;
  logic [W-1:0]                      op_b_q;
  logic [W-1:0]                      sum_q;

  logic [W-1:0]                      a_q;
  logic [W-1:0]                      b_q;
  logic [W-1:0]                      c_q;
  logic                              b_vld;
  logic                              b_ack;

  // bus front end
  assign req    = wb_req_i.cyc & wb_req_i.stb;
  assign adr_w  = {wb_req_i.adr[axlcs_pkg::AW-1:2], 2'b00};
  assign wr_cmt = req & ack_q & wb_req_i.we;
  assign wr_b0  = wr_cmt & wb_req_i.sel[0];
  assign rd_take = req & ~ack_q & ~wb_req_i.we;

  // one-cycle ack
  // unmapped addresses are acknowledged too and read as zero
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q <= axlcs_pkg::DATA_RST;
    end else if (rd_take) begin
      rdata_q <= rdata_d;
    end
  end

  // one driver for the whole response carrier
  assign wb_rsp_o = '{dat: rdata_q, ack: ack_q};

  always_comb begin
    rdata_d = '0;
    case (adr_w)
      axlcs_pkg::ADR_CTRL: begin
        rdata_d[axlcs_pkg::CTRL_START] = start_q;
        rdata_d[axlcs_pkg::CTRL_DONE]  = done_q;
        rdata_d[axlcs_pkg::CTRL_IDLE]  = idle_o;
        rdata_d[axlcs_pkg::CTRL_READY] = ready_evt;
        rdata_d[axlcs_pkg::CTRL_AUTO]  = auto_q;
      end
      axlcs_pkg::ADR_GIE: begin
        rdata_d[axlcs_pkg::GIE_BIT] = gie_q;
      end
      axlcs_pkg::ADR_IER: begin
        rdata_d[axlcs_pkg::IRQ_N-1:0] = ier_q;
      end
      axlcs_pkg::ADR_ISR: begin
        rdata_d[axlcs_pkg::IRQ_N-1:0] = isr_q;
      end
      axlcs_pkg::ADR_A: begin
        rdata_d[W-1:0] = a_q;
      end
      axlcs_pkg::ADR_B: begin
        rdata_d[W-1:0] = b_q;
      end
      axlcs_pkg::ADR_B_VLD: begin
        rdata_d[axlcs_pkg::HSK_BIT] = b_vld;
      end
      axlcs_pkg::ADR_B_ACK: begin
        rdata_d[axlcs_pkg::HSK_BIT] = b_ack;
      end
      axlcs_pkg::ADR_C: begin
        rdata_d[W-1:0] = c_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // block control: start is write-one-to-set, cleared when inputs are taken unless auto restart is set
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      start_q <= 1'b0;
    end else if (wr_b0 && adr_w == axlcs_pkg::ADR_CTRL
                 && wb_req_i.dat[axlcs_pkg::CTRL_START]) begin
      start_q <= 1'b1;
    end else if (ready_evt && !auto_q) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      auto_q <= 1'b0;
    end else if (wr_b0 && adr_w == axlcs_pkg::ADR_CTRL) begin
      auto_q <= wb_req_i.dat[axlcs_pkg::CTRL_AUTO];
    end
  end

  // sticky completion flag
  // cleared when the control word is read; a completion in that cycle wins
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      done_q <= 1'b0;
    end else if (done_evt) begin
      done_q <= 1'b1;
    end else if (rd_take && adr_w == axlcs_pkg::ADR_CTRL) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gie_q <= 1'b0;
    end else if (wr_b0 && adr_w == axlcs_pkg::ADR_GIE) begin
      gie_q <= wb_req_i.dat[axlcs_pkg::GIE_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ier_q <= axlcs_pkg::IRQ_RST;
    end else if (wr_b0 && adr_w == axlcs_pkg::ADR_IER) begin
      ier_q <= wb_req_i.dat[axlcs_pkg::IRQ_N-1:0];
    end
  end

  always_comb begin
    isr_set = '0;
    isr_set[axlcs_pkg::IRQ_DONE]  = done_evt;
    isr_set[axlcs_pkg::IRQ_READY] = ready_evt;
    isr_clr = '0;
    if (wr_b0 && adr_w == axlcs_pkg::ADR_ISR) begin
      isr_clr = wb_req_i.dat[axlcs_pkg::IRQ_N-1:0];
    end
  end

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      isr_q <= axlcs_pkg::IRQ_RST;
    end else begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= gie_q & (|(isr_q & ier_q));
    end
  end

  // no port below the control window
  axlcs_arg_reg #(
    .W        (W),
    .RESET_EN (REG_RESET_EN)
  ) u_arg_a (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_b0 && adr_w == axlcs_pkg::ADR_A),
    .wr_dat_i  (wb_req_i.dat[W-1:0]),
    .ld_en_i   (1'b0),
    .ld_dat_i  ('0),
    .q_o       (a_q)
  );

  axlcs_arg_reg #(
    .W        (W),
    .RESET_EN (REG_RESET_EN)
  ) u_arg_b (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_b0 && adr_w == axlcs_pkg::ADR_B),
    .wr_dat_i  (wb_req_i.dat[W-1:0]),
    .ld_en_i   (1'b0),
    .ld_dat_i  ('0),
    .q_o       (b_q)
  );

  // result is written back into c; the core write wins over software
  axlcs_arg_reg #(
    .W        (W),
    .RESET_EN (REG_RESET_EN)
  ) u_arg_c (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_b0 && adr_w == axlcs_pkg::ADR_C),
    .wr_dat_i  (wb_req_i.dat[W-1:0]),
    .ld_en_i   (done_evt),
    .ld_dat_i  (sum_q),
    .q_o       (c_q)
  );

  axlcs_hsk_port u_hsk_b (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .vld_wr_i  (wr_b0 && adr_w == axlcs_pkg::ADR_B_VLD),
    .vld_dat_i (wb_req_i.dat[axlcs_pkg::HSK_BIT]),
    .consume_i (b_take),
    .valid_o   (b_vld),
    .ack_o     (b_ack)
  );

  assign b_ack_o = b_ack;

  // core sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      axlcs_pkg::ST_IDLE: begin
        if (start_q) begin
          state_d = axlcs_pkg::ST_RD_A;
        end
      end
      axlcs_pkg::ST_RD_A: begin
        state_d = axlcs_pkg::ST_WAIT_B;
      end
      axlcs_pkg::ST_WAIT_B: begin
        if (b_vld) begin
          state_d = axlcs_pkg::ST_CALC;
        end
      end
      axlcs_pkg::ST_CALC: begin
        state_d = axlcs_pkg::ST_DONE;
      end
      axlcs_pkg::ST_DONE: begin
        state_d = axlcs_pkg::ST_IDLE;
      end
      default: begin
        state_d = axlcs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= axlcs_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign b_take    = (state_q == axlcs_pkg::ST_WAIT_B) & b_vld;
  assign ready_evt = b_take;
  assign done_evt  = (state_q == axlcs_pkg::ST_DONE);
  assign idle_o    = (state_q == axlcs_pkg::ST_IDLE);

  // operands are latched so software may rewrite a and b while the core runs
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      op_a_q <= '0;
    end else if (state_q == axlcs_pkg::ST_RD_A) begin
      op_a_q <= a_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      op_b_q <= '0;
    end else if (b_take) begin
      op_b_q <= b_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sum_q <= '0;
    end else if (state_q == axlcs_pkg::ST_CALC) begin
      sum_q <= W'(c_q + op_a_q + op_b_q);
    end
  end

  // checks
  sequence s_b_wait;
    (state_q == axlcs_pkg::ST_WAIT_B) && !b_vld;
  endsequence

  sequence s_b_take;
    (state_q == axlcs_pkg::ST_WAIT_B) && b_vld;
  endsequence

  sequence s_finish;
    (state_q == axlcs_pkg::ST_CALC) ##1 (state_q == axlcs_pkg::ST_DONE);
  endsequence

  property p_ack_follows;
    @(posedge clock_i) disable iff (sys_rst_i)
      req && !ack_q |=> ack_q;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("request not acknowledged in one cycle");

  property p_ack_pulse;
    @(posedge clock_i) disable iff (sys_rst_i)
      ack_q |=> !ack_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_b_stall;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_b_wait |=> (state_q == axlcs_pkg::ST_WAIT_B) && !done_evt;
  endproperty
  a_b_stall: assert property (p_b_stall)
    else $error("core left wait without valid b");

  property p_b_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_b_take and !(wr_b0 && adr_w == axlcs_pkg::ADR_B_VLD) |=> !b_vld;
  endproperty
  a_b_clear: assert property (p_b_clear)
    else $error("valid of b not cleared after consume");

  property p_b_ack;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_b_take |=> b_ack ##1 (state_q == axlcs_pkg::ST_DONE);
  endproperty
  a_b_ack: assert property (p_b_ack)
    else $error("acknowledge of b missing after consume");

  property p_rsv_window;
    @(posedge clock_i) disable iff (sys_rst_i)
      wr_cmt && adr_w <= axlcs_pkg::ADR_RSV_HI |=> $stable(a_q) && $stable(b_q);
  endproperty
  a_rsv_window: assert property (p_rsv_window)
    else $error("control window write changed a port register");

  property p_c_offset;
    @(posedge clock_i) disable iff (sys_rst_i)
      wr_b0 && adr_w == axlcs_pkg::ADR_C && !done_evt
      |=> c_q == $past(wb_req_i.dat[W-1:0]);
  endproperty
  a_c_offset: assert property (p_c_offset)
    else $error("write at explicit offset did not reach c");

  property p_done_flag;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_finish |=> done_q && (c_q == $past(sum_q)) && idle_o;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("completion not flagged or result not written");

  property p_irq_done;
    @(posedge clock_i) disable iff (sys_rst_i)
      done_evt && gie_q && ier_q[axlcs_pkg::IRQ_DONE] && !wr_cmt |-> ##2 irq_o;
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("completion did not raise the interrupt");

  property p_irq_ready;
    @(posedge clock_i) disable iff (sys_rst_i)
      ready_evt ##1 (gie_q && ier_q[axlcs_pkg::IRQ_READY] && !wr_cmt) |=> irq_o;
  endproperty
  a_irq_ready: assert property (p_irq_ready)
    else $error("input-ready did not raise the interrupt");

  property p_irq_off;
    @(posedge clock_i) disable iff (sys_rst_i)
      !gie_q |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with global enable off");
endmodule
`default_nettype wire

// *** tb/axlcs_wb_master.sv ***
// classic wishbone master standing in for the processor on the far side
// assumes the slave answers with a registered ack; the bench calls xfer hierarchically
`timescale 1ns/10ps
`default_nettype none
module axlcs_wb_master (
  // clock
  input  wire logic                     clock_i,
  // register bus
  output var  axlcs_pkg::axlcs_wb_req_t wb_req_o,
  input  wire axlcs_pkg::axlcs_wb_rsp_t wb_rsp_i
);
  // extra idle cycles before a request, to play a slow processor
  int idle_gap = 0;

  initial wb_req_o = '0;

  task automatic xfer(input logic we, input logic [axlcs_pkg::AW-1:0] adr,
                      input logic [axlcs_pkg::DW-1:0] dat, input logic [axlcs_pkg::SW-1:0] sel,
                      output logic [axlcs_pkg::DW-1:0] rdat, output bit ok);
    ok = 1'b0;
    rdat = '0;
    repeat (idle_gap) @(posedge clock_i);
    @(posedge clock_i);
    wb_req_o <= '{adr: adr, dat: dat, sel: sel, we: we, cyc: 1'b1, stb: 1'b1};
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge clock_i);
      if (wb_rsp_i.ack === 1'b1) begin
        ok = 1'b1;
        rdat = wb_rsp_i.dat;
      end
    end
    // released lines carry the inverse, so a stale value is never mistaken for a request
    wb_req_o <= '{adr: ~adr, dat: ~dat, sel: ~sel, we: ~we, cyc: 1'b0, stb: 1'b0};
  endtask
endmodule
`default_nettype wire

// *** tb/axlcs_top_bench.sv ***
// self-checking bench for the control slave and its small core
// assumes the master model drives the bus; the bench drives clock and reset
`timescale 1ns/10ps
`default_nettype none
module axlcs_top_bench;
  logic                     clock_i   = 1'b0;
  logic                     sys_rst_i = 1'b1;
  axlcs_pkg::axlcs_wb_req_t wb_req;
  axlcs_pkg::axlcs_wb_rsp_t wb_rsp;
  logic                     irq;
  logic                     idle;
  logic                     b_ack;
  int                       miscompares = 0;
  int                       checked     = 0;
  logic [11:0]              rst_adr [9];

  always #2 clock_i = ~clock_i;

  axlcs_top u_axlcs_top (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wb_req_i  (wb_req),
    .wb_rsp_o  (wb_rsp),
    .irq_o     (irq),
    .idle_o    (idle),
    .b_ack_o   (b_ack)
  );

  axlcs_wb_master u_axlcs_wb_master (
    .clock_i  (clock_i),
    .wb_req_o (wb_req),
    .wb_rsp_i (wb_rsp)
  );

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel, output logic [31:0] rdat);
    bit ok;
    u_axlcs_wb_master.xfer(we, adr, dat, sel, rdat, ok);
    if (!ok) begin
      miscompares++;
      $display("[FAIL] bus ack at %h expected 1 seen 0", adr);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    bus(1'h1, adr, dat, 4'hF, unused);
  endtask

  task automatic rd(input string name, input logic [11:0] adr, input logic [31:0] exp);
    logic [31:0] seen;
    bus(1'h0, adr, 32'h0000_0000, 4'hF, seen);
    check(name, seen, exp);
  endtask

  // bounded wait on the core idle level
  task automatic wait_idle(input logic lvl);
    for (int i = 0; i < 100; i++) begin
      @(posedge clock_i);
      if (idle === lvl) return;
    end
    miscompares++;
    $display("[FAIL] idle expected %b seen %b", lvl, idle);
    end_of_test();
  endtask

  initial begin
    rst_adr = '{axlcs_pkg::ADR_CTRL, axlcs_pkg::ADR_GIE, axlcs_pkg::ADR_IER,
                axlcs_pkg::ADR_ISR, axlcs_pkg::ADR_A, axlcs_pkg::ADR_B,
                axlcs_pkg::ADR_B_VLD, axlcs_pkg::ADR_B_ACK, axlcs_pkg::ADR_C};
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 9; i++) begin
      rd("reset value", rst_adr[i], (i == 0) ? 32'h0000_0004 : 32'h0000_0000);
    end
    check("irq after reset", 32'(irq), 32'h0000_0000);
    check("b ack after reset", 32'(b_ack), 32'h0000_0000);
    $display("test reset done");

    wr(axlcs_pkg::ADR_A, 32'h0000_0011);
    wr(axlcs_pkg::ADR_B, 32'h0000_0022);
    wr(axlcs_pkg::ADR_C, 32'h0000_0005);
    wr(axlcs_pkg::ADR_GIE, 32'h0000_0001);
    wr(axlcs_pkg::ADR_IER, 32'h0000_0003);
    wr(axlcs_pkg::ADR_CTRL, 32'h0000_0001);
    wait_idle(1'h0);
    // hold off long enough that a core ignoring valid would have finished
    repeat (10) @(posedge clock_i);
    check("idle while stalled", 32'(idle), 32'h0000_0000);
    check("b ack while stalled", 32'(b_ack), 32'h0000_0000);
    rd("c while stalled", axlcs_pkg::ADR_C, 32'h0000_0005);
    wr(axlcs_pkg::ADR_B_VLD, 32'h0000_0001);
    wait_idle(1'h1);
    rd("ctrl done", axlcs_pkg::ADR_CTRL, 32'h0000_0006);
    rd("ctrl done cleared", axlcs_pkg::ADR_CTRL, 32'h0000_0004);
    rd("isr both events", axlcs_pkg::ADR_ISR, 32'h0000_0003);
    check("irq raised", 32'(irq), 32'h0000_0001);
    rd("c result", axlcs_pkg::ADR_C, 32'h0000_0038);
    rd("b valid cleared", axlcs_pkg::ADR_B_VLD, 32'h0000_0000);
    rd("b ack set", axlcs_pkg::ADR_B_ACK, 32'h0000_0001);
    rd("a after window writes", axlcs_pkg::ADR_A, 32'h0000_0011);
    check("b ack pin set", 32'(b_ack), 32'h0000_0001);
    $display("test handshake run done");

    wr(axlcs_pkg::ADR_ISR, 32'h0000_0003);
    rd("isr cleared", axlcs_pkg::ADR_ISR, 32'h0000_0000);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    wr(axlcs_pkg::ADR_IER, 32'h0000_0000);
    wr(axlcs_pkg::ADR_B_VLD, 32'h0000_0001);
    rd("b ack cleared", axlcs_pkg::ADR_B_ACK, 32'h0000_0000);
    check("b ack pin cleared", 32'(b_ack), 32'h0000_0000);
    wr(12'h100, 32'h0000_00AA);
    rd("unmapped read", 12'h100, 32'h0000_0000);
    begin : masked_lane
      logic [31:0] unused;
      bus(1'h1, axlcs_pkg::ADR_A, 32'h0000_0099, 4'h2, unused);
    end
    rd("a after lane 1 write", axlcs_pkg::ADR_A, 32'h0000_0011);
    $display("test bus corners done");

    u_axlcs_wb_master.idle_gap = 3;
    wr(axlcs_pkg::ADR_CTRL, 32'h0000_0001);
    wait_idle(1'h0);
    wait_idle(1'h1);
    rd("c second run", axlcs_pkg::ADR_C, 32'h0000_006B);
    rd("isr masked run", axlcs_pkg::ADR_ISR, 32'h0000_0003);
    check("irq masked", 32'(irq), 32'h0000_0000);
    $display("test masked run done");

    // auto restart keeps start set, so the core comes back to stall on b
    wr(axlcs_pkg::ADR_CTRL, 32'h0000_0081);
    wr(axlcs_pkg::ADR_B_VLD, 32'h0000_0001);
    wait_idle(1'h1);
    wait_idle(1'h0);
    rd("ctrl auto restart", axlcs_pkg::ADR_CTRL, 32'h0000_0083);
    check("idle in restarted stall", 32'(idle), 32'h0000_0000);
    rd("c after auto run", axlcs_pkg::ADR_C, 32'h0000_009E);
    wr(axlcs_pkg::ADR_CTRL, 32'h0000_0000);
    wr(axlcs_pkg::ADR_B_VLD, 32'h0000_0001);
    wait_idle(1'h1);
    repeat (4) @(posedge clock_i);
    check("idle after auto off", 32'(idle), 32'h0000_0001);
    rd("ctrl after auto off", axlcs_pkg::ADR_CTRL, 32'h0000_0006);
    rd("c after auto off", axlcs_pkg::ADR_C, 32'h0000_00D1);
    $display("test auto restart done");
    end_of_test();
  end
endmodule
`default_nettype wire
